// ===== tso_pkg.sv
/*
  Package for the transport stream output port: register offsets, reset
  values, status bit positions, packet framing counts and the carrier structs.
  Assumes a 32-bit APB register bus and one 25 MHz core clock.
*/
package tso_pkg;

  // register byte offsets, one aligned word each
  localparam logic [11:0] OFF_CTRL   = 12'h0000;
  localparam logic [11:0] OFF_STATUS = 12'h0004;
  localparam logic [11:0] OFF_MASK   = 12'h0008;
  localparam logic [11:0] OFF_STATE  = 12'h000C;

  // control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SERIAL_BIT = 1;
  localparam int CTRL_REDUND_BIT = 2;
  localparam int CTRL_CLKINV_BIT = 3;
  localparam int CTRL_SOPINV_BIT = 4;
  localparam int CTRL_VLDINV_BIT = 5;
  localparam int CTRL_ERRINV_BIT = 6;
  localparam int CTRL_DIV_LSB    = 8;

  // status / mask bit positions
  localparam int ST_PKT_BIT   = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_UNDER_BIT = 2;
  localparam int ST_SYNC_BIT  = 3;
  localparam int ST_W         = 4;

  // values after reset
  localparam logic [31:0]     CTRL_RST   = 32'h0000_0000;
  localparam logic [ST_W-1:0] STATUS_RST = 4'h0;
  localparam logic [ST_W-1:0] MASK_RST   = 4'h0;

  // packet framing counts
  localparam logic [7:0] PKT_DATA_BYTES = 8'd188;
  localparam logic [7:0] PARITY_BYTES   = 8'd20;
  localparam logic [2:0] BITS_LEFT_SER  = 3'd7;

  // decoded control register
  typedef struct packed {
    logic [7:0] half_div;
    logic       err_inv;
    logic       vld_inv;
    logic       sop_inv;
    logic       clk_inv;
    logic       redund;
    logic       serial;
    logic       enable;
  } tso_ctrl_s;

  // stream pins leaving the device
  typedef struct packed {
    logic       clk;
    logic [7:0] pdata;
    logic       sdata;
    logic       sop;
    logic       valid;
    logic       err;
  } tso_pins_s;

endpackage : tso_pkg

// ===== tso_top.sv
/*
  Transport stream output port. Takes bytes from the error-correction stage
  on a valid/ready handshake and sends 188-byte packets out in parallel or
  serial form, data only or with parity bytes, with a generated output byte
  clock and programmable flag polarity. Registers are on APB.
  Assumes: source logic on core_clk_i, power_on_reset_n_i from a board pin,
  the source supplies parity bytes right behind the data in redundancy modes.
  Limitations: the line rate is a fraction of the core clock, so the faster
  serial rates need a faster core; a late source byte stalls the clock high
  rather than inserting a gap byte, so the receiver sees a longer period.
  The first rising edge after enable carries no byte yet; a receiver should
  align on its first falling edge or on the start flag.

*/
// Register access over APB and the register addresses were decided locally.
module tso_top (
  // clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        power_on_reset_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  // byte source
  input  wire logic        in_valid_i,
  input  wire logic [7:0]  in_data_i,
  input  wire logic        in_sop_i,
  input  wire logic        in_err_i,
  output logic             in_ready_o,
  // stream pins
  output logic             output_byte_clock_o,
  output logic [7:0]       parallel_data_out_o,
  output logic             serial_data_out_o,
  output logic             packet_start_o,
  output logic             packet_valid_strobe_o,
  output logic             packet_error_flag_o,
  // interrupt
  output logic             irq_o
);

  // power-on reset synchroniser
  logic por_meta_ff;
  logic por_sync_ff;
  logic rst_all;

  // registers
  tso_pkg::tso_ctrl_s          ctrl_ff;
  logic [tso_pkg::ST_W-1:0]    status_ff;
  logic [tso_pkg::ST_W-1:0]    mask_ff;
  logic [31:0]                 prdata_ff;

  // output engine state
  logic [10:0]     div_cnt_ff;
  logic            clk_int_ff;
  logic [7:0]      shift_ff;
  logic [2:0]      bits_left_ff;
  logic [7:0]      pos_ff;
  logic            active_ff;
  logic            err_pkt_ff;
  tso_pkg::tso_pins_s pins_ff;
  tso_pkg::tso_pins_s nxt_pins;

  // combinational helpers
  logic [10:0]     reload;
  logic [7:0]      last_pos;
  logic            tick;
  logic            fall_due;
  logic            need_byte;
  logic            load_byte;
  logic            shift_bit;
  logic            stall;
  logic            new_pkt;
  logic            sync_bad;
  logic [tso_pkg::ST_W-1:0] evt;
  logic            wr_acc;
  logic            rd_setup;
  logic            addr_ok;

  // async assert, clocked release; the first flop feeds only the second
  // a release close to a clock edge may leave the first flop metastable,
  // so only the second flop is allowed to reach the reset tree
  always_ff @(posedge core_clk_i or negedge power_on_reset_n_i) begin
    if (!power_on_reset_n_i) begin
      por_meta_ff <= 1'b0;
      por_sync_ff <= 1'b0;
    end else begin
      por_meta_ff <= 1'b1;
      por_sync_ff <= por_meta_ff;
    end
  end

  // either reset source holds the block; the pin one only after sync
  assign rst_all = rst_i | ~por_sync_ff;

  // apb decode: zero wait states, read data captured in the setup phase
  // capturing early keeps prdata on a flop at the cost of one cycle of age:
  // a status bit set during the access phase shows up on the next read
  // slverr is combinational so it stands exactly with the access phase
  assign wr_acc   = psel_i & penable_i & pwrite_i & ce_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i & ce_i;
  assign addr_ok  = (paddr_i == tso_pkg::OFF_CTRL) | (paddr_i == tso_pkg::OFF_STATUS) |
                    (paddr_i == tso_pkg::OFF_MASK) | (paddr_i == tso_pkg::OFF_STATE);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign prdata_o  = prdata_ff;

  // control register: mode, polarity and divider
  // bit 7 is unused so the divider sits on its own byte; the struct skips
  // it, so writes and readback keep the same layout
  // changing mode while enabled may cut a packet; disable first
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      ctrl_ff <= tso_pkg::tso_ctrl_s'({tso_pkg::CTRL_RST[15:8], tso_pkg::CTRL_RST[6:0]});
    end else if (wr_acc && paddr_i == tso_pkg::OFF_CTRL) begin
      ctrl_ff <= tso_pkg::tso_ctrl_s'({pwdata_i[15:8], pwdata_i[6:0]});
    end
  end

  // mask register
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      mask_ff <= tso_pkg::MASK_RST;
    end else if (wr_acc && paddr_i == tso_pkg::OFF_MASK) begin
      mask_ff <= pwdata_i[tso_pkg::ST_W-1:0];
    end
  end

  // sticky status: write one to clear, a new event in the same cycle wins
  // letting the event win means software never loses an event that lands
  // on the very cycle of its own clear
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      status_ff <= tso_pkg::STATUS_RST;
    end else if (ce_i) begin
      if (wr_acc && paddr_i == tso_pkg::OFF_STATUS) begin
        status_ff <= (status_ff & ~pwdata_i[tso_pkg::ST_W-1:0]) | evt;
      end else begin
        status_ff <= status_ff | evt;
      end
    end
  end

  // level interrupt while any unmasked status bit is set
  // combinational from two flops, so it drops in the cycle after the clear
  assign irq_o = |(status_ff & mask_ff);

  // read data register, unmapped offsets read zero
  // the control word is rebuilt around the unused bit 7
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr_i)
        tso_pkg::OFF_CTRL:   prdata_ff <= {16'h0000, ctrl_ff.half_div, 1'h0, ctrl_ff[6:0]};
        tso_pkg::OFF_STATUS: prdata_ff <= {28'h000_0000, status_ff};
        tso_pkg::OFF_MASK:   prdata_ff <= {28'h000_0000, mask_ff};
        tso_pkg::OFF_STATE:  prdata_ff <= {14'h0000, active_ff, err_pkt_ff,
                                           bits_left_ff, clk_int_ff, 4'h0, pos_ff};
        default:             prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // half-period reload: parallel mode stretches the period eightfold so one
  // divider setting gives the same line rate in both forms
  assign reload = ctrl_ff.serial ? {3'b000, ctrl_ff.half_div}
                                 : {ctrl_ff.half_div, 3'b111};

  // last byte index of a frame: data only, or data plus parity
  assign last_pos = ctrl_ff.redund ? 8'(tso_pkg::PKT_DATA_BYTES + tso_pkg::PARITY_BYTES - 8'd1)
                                   : 8'(tso_pkg::PKT_DATA_BYTES - 8'd1);

  // edge scheduling: a falling edge is where new data is launched
  // the ready pulse is combinational so the byte is taken on the same edge
  // that launches it; a registered ready would cost a whole half period
  // while the clock waits for data, ready stays up until a byte arrives
  // and the divider holds at zero so the next edge comes at once
  assign tick      = ctrl_ff.enable & (div_cnt_ff == 11'h000);
  assign fall_due  = tick & clk_int_ff;
  assign need_byte = (bits_left_ff == 3'd0);
  assign load_byte = fall_due & need_byte & in_valid_i & ce_i;
  assign shift_bit = fall_due & ~need_byte & ce_i;
  // with no byte ready the clock stops high rather than send a gap byte
  assign stall     = fall_due & need_byte & ~in_valid_i;
  assign in_ready_o = fall_due & need_byte & ce_i;
  assign new_pkt   = load_byte & (in_sop_i | ~active_ff | (pos_ff == last_pos));
  assign sync_bad  = load_byte & active_ff & (in_sop_i != (pos_ff == last_pos));

  // events for the status register
  always_comb begin
    evt = '0;
    evt[tso_pkg::ST_PKT_BIT]   = new_pkt;
    evt[tso_pkg::ST_ERR_BIT]   = new_pkt & in_err_i;
    evt[tso_pkg::ST_UNDER_BIT] = stall & active_ff & ce_i;
    evt[tso_pkg::ST_SYNC_BIT]  = sync_bad;
  end

  // divider counting half periods of the output byte clock
  // while disabled it is preloaded, so the first half period after enable
  // has the length of the mode that was set before the enabling write
  // a stall parks it at zero instead of reloading, which keeps the clock
  // high for as long as the source is late
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      div_cnt_ff <= 11'h000;
    end else if (ce_i) begin
      if (!ctrl_ff.enable) begin
        div_cnt_ff <= reload;
      end else if (tick) begin
        if (!stall) begin
          div_cnt_ff <= reload;
        end
      end else begin
        div_cnt_ff <= div_cnt_ff - 11'd1;
      end
    end
  end

  // internal clock phase, true polarity; rises mid-bit, falls to launch
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      clk_int_ff <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_ff.enable) begin
        clk_int_ff <= 1'b0;
      end else if (tick && !stall) begin
        clk_int_ff <= ~clk_int_ff;
      end
    end
  end

  // data byte and serial bit position; msb goes out first
  // the parallel bus shows the shift register too, so in serial mode it
  // walks left once per bit; receivers must ignore it in that mode
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      shift_ff     <= 8'h00;
      bits_left_ff <= 3'd0;
    end else if (ce_i) begin
      if (!ctrl_ff.enable) begin
        bits_left_ff <= 3'd0;
      end else if (load_byte) begin
        shift_ff     <= in_data_i;
        bits_left_ff <= ctrl_ff.serial ? tso_pkg::BITS_LEFT_SER : 3'd0;
      end else if (shift_bit) begin
        shift_ff     <= {shift_ff[6:0], 1'b0};
        bits_left_ff <= bits_left_ff - 3'd1;
      end
    end
  end

  // byte position within the frame; parity runs on from data with no gap
  // a start marker from the source restarts the count at once, so a lost
  // byte costs one short packet rather than a permanently shifted frame
  // the mismatch is still reported through the sync status bit
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      pos_ff    <= 8'h00;
      active_ff <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_ff.enable) begin
        active_ff <= 1'b0;
        pos_ff    <= 8'h00;
      end else if (load_byte) begin
        active_ff <= 1'b1;
        pos_ff    <= new_pkt ? 8'h00 : pos_ff + 8'd1;
      end
    end
  end

  // packet error is caught with the first byte and held to the packet end
  // an error marker on a later byte is ignored; the source must know the
  // verdict for the whole packet before it hands over the first byte
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      err_pkt_ff <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_ff.enable) begin
        err_pkt_ff <= 1'b0;
      end else if (new_pkt) begin
        err_pkt_ff <= in_err_i;
      end
    end
  end

  // pin values before registering; polarity applied per signal
  // inversion sits after the logic so every flag keeps one internal sense
  // flipping a polarity bit while enabled shows a false edge on that pin
  // that stays at the new level
  always_comb begin
    nxt_pins       = '0;
    nxt_pins.clk   = clk_int_ff ^ ctrl_ff.clk_inv;
    nxt_pins.pdata = shift_ff;
    nxt_pins.sdata = shift_ff[7];
    // start spans the whole first byte, i.e. eight bit clocks in serial
    nxt_pins.sop   = (active_ff & (pos_ff == 8'h00)) ^ ctrl_ff.sop_inv;
    // data only: always valid; redundancy: valid over the data bytes only
    nxt_pins.valid = (active_ff & (~ctrl_ff.redund |
                     (pos_ff < tso_pkg::PKT_DATA_BYTES))) ^ ctrl_ff.vld_inv;
    nxt_pins.err   = (active_ff & err_pkt_ff) ^ ctrl_ff.err_inv;
  end

  // registered pins: clock and data share one stage, so data still changes
  // on the launching edge and stays put across the sampling edge
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      pins_ff <= '0;
    end else if (ce_i) begin
      pins_ff <= nxt_pins;
    end
  end

  // drive the pins
  // all pins come straight from one register stage, so they leave the
  // device with matched delay and no combinational glitches
  assign output_byte_clock_o   = pins_ff.clk;
  assign parallel_data_out_o   = pins_ff.pdata;
  assign serial_data_out_o     = pins_ff.sdata;
  assign packet_start_o        = pins_ff.sop;
  assign packet_valid_strobe_o = pins_ff.valid;
  assign packet_error_flag_o   = pins_ff.err;

endmodule : tso_top

// ===== tso_monitor.sv
/*
  tso_monitor: assertions on the pins of tso_top.
  Assumes ctrl and mask change only by apb writes.
*/
module tso_monitor (
  // clock and resets
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        power_on_reset_n_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // stream and interrupt
  input wire logic        in_valid_i,
  input wire logic        in_ready_o,
  input wire logic        output_byte_clock_o,
  input wire logic [7:0]  parallel_data_out_o,
  input wire logic        packet_start_o,
  input wire logic        packet_valid_strobe_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ctrl_ff;
  logic [3:0]  mask_ff;
  logic        s_ff, v_ff, seen_ff, wr, wc, s_act, v_act, rise;
  int          scnt_ff, vcnt_ff, st_ff, bp;
  assign wr    = psel_i && penable_i && pwrite_i;
  assign wc    = wr && paddr_i == tso_pkg::OFF_CTRL;
  assign s_act = packet_start_o ^ ctrl_ff[4];
  assign v_act = packet_valid_strobe_o ^ ctrl_ff[5];
  assign rise  = s_act && !s_ff;
  assign bp    = 16 * (int'(ctrl_ff[15:8]) + 1); // core cycles per byte, both modes

  // shadow of the control and mask registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !power_on_reset_n_i) begin
      ctrl_ff <= 32'h0000_0000;
      mask_ff <= 4'h0;
    end else if (wc) ctrl_ff <= pwdata_i;
    else if (wr && paddr_i == tso_pkg::OFF_MASK) mask_ff <= pwdata_i[3:0];
  end

  // run lengths; a ctrl write restarts the settle count st_ff and clears seen_ff, since a polarity flip fakes an edge
  always_ff @(posedge core_clk_i) begin
    s_ff    <= s_act;
    v_ff    <= v_act;
    vcnt_ff <= v_act ? vcnt_ff + 1 : 0;
    if (rst_i || wc) begin
      st_ff   <= 0;
      seen_ff <= 1'b0;
    end else begin
      if (st_ff < 9999) st_ff <= st_ff + 1;
      scnt_ff <= rise ? 1 : scnt_ff + 1;
      if (rise && st_ff > 4) seen_ff <= 1'b1;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i || !power_on_reset_n_i);

  sequence s_first_byte;
    s_act [*8] ##1 s_act [*8];
  endsequence
  property p_ready; pready_o; endproperty
  property p_slverr; psel_i && penable_i && paddr_i > 12'h000C |-> pslverr_o; endproperty
  property p_irq; mask_ff == 4'h0 |-> !irq_o; endproperty
  property p_edge;
    ctrl_ff[0] && st_ff > 4 && $changed(parallel_data_out_o)
      |-> $changed(output_byte_clock_o) && output_byte_clock_o == ctrl_ff[3];
  endproperty
  property p_ser_start;
    ctrl_ff[1] && ctrl_ff[15:8] == 8'h00 && rise && st_ff > 4 |-> s_first_byte ##1 !s_act;
  endproperty
  property p_frame; rise && seen_ff |-> scnt_ff == (ctrl_ff[2] ? 208 : 188) * bp; endproperty
  property p_vld_len; ctrl_ff[2] && !v_act && v_ff && st_ff > 4000 |-> vcnt_ff == 188 * bp;
  endproperty
  property p_vld_keep; ctrl_ff[0] && !ctrl_ff[2] && seen_ff |-> v_act; endproperty
  // a stalled launch keeps ready up; once a byte is taken it must drop
  property p_rdy_pulse; in_ready_o && in_valid_i |=> !in_ready_o; endproperty
  property p_por;
    // the pin reset clears the synchronous flops at the edge after it falls
    disable iff (rst_i) !power_on_reset_n_i && $past(!power_on_reset_n_i)
      |-> !packet_valid_strobe_o && !output_byte_clock_o && !irq_o && !in_ready_o;
  endproperty

  a_ready: assert property (p_ready) else $error("pready low");
  a_slverr: assert property (p_slverr) else $error("no slverr on unmapped address");
  a_irq: assert property (p_irq) else $error("irq with all masked");
  a_edge: assert property (p_edge) else $error("data moved off the launch edge");
  a_ser_start: assert property (p_ser_start) else $error("serial start length");
  a_frame: assert property (p_frame) else $error("packet spacing");
  a_vld_len: assert property (p_vld_len) else $error("valid length");
  a_vld_keep: assert property (p_vld_keep) else $error("valid dropped");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  a_por: assert property (p_por) else $error("pins active in power-on reset");
endmodule : tso_monitor

bind tso_top tso_monitor mon_u (.*);

// ===== tso_sink.sv
/*
  tso_sink: backend receiver model, samples the stream pins on the rising
  edge of the active output clock. Assumes pins are synchronous to core_clk_i.
*/
module tso_sink (
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  // stream pins and the control they were sent with
  input wire tso_pkg::tso_pins_s pins_i,
  input wire tso_pkg::tso_ctrl_s ctrl_i,
  // received byte
  output logic                  stb_o,
  output logic [7:0]            byte_o,
  output logic                  start_o,
  output logic                  valid_o,
  output logic                  err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_ff, all_ff, clk_act, s_all, live_ff;
  logic [1:0] en_ff;
  logic [2:0] cnt_ff;
  logic [7:0] sh_ff;
  assign clk_act = pins_i.clk ^ ctrl_i.clk_inv;
  assign s_all   = (cnt_ff == 3'd0 || all_ff) && (pins_i.sop ^ ctrl_i.sop_inv);

  // capture on the rising edge; the pins moved half a period earlier
  // two cycles of settling after enable hide the polarity switch-over
  // the first rise after enable carries no byte, so capture waits for a fall
  always_ff @(posedge core_clk_i) begin
    clk_ff <= clk_act;
    en_ff  <= {en_ff[0], ctrl_i.enable};
    stb_o  <= 1'b0;
    if (rst_i || en_ff != 2'b11) begin
      cnt_ff  <= 3'd0;
      live_ff <= 1'b0;
    end else if (!clk_act && clk_ff) begin
      live_ff <= 1'b1;
    end else if (clk_act && !clk_ff && live_ff) begin
      sh_ff  <= {sh_ff[6:0], pins_i.sdata}; // msb first
      all_ff <= s_all;
      cnt_ff <= ctrl_i.serial ? cnt_ff + 3'd1 : 3'd0;
      if (!ctrl_i.serial || cnt_ff == 3'd7) begin
        stb_o   <= 1'b1;
        byte_o  <= ctrl_i.serial ? {sh_ff[6:0], pins_i.sdata} : pins_i.pdata;
        start_o <= s_all;
        valid_o <= pins_i.valid ^ ctrl_i.vld_inv;
        err_o   <= pins_i.err ^ ctrl_i.err_inv;
      end
    end
  end
endmodule : tso_sink

// ===== tb_top.sv
/*
  tb_top: drives tso_top over apb and a byte source, checks the stream
  through tso_sink. Assumes one 25 MHz core clock.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, por_n = 0, psel = 0, pen = 0, pwr = 0, slv, chk_on = 0, perr = 0;
  logic in_valid = 0, in_sop = 0, in_err = 0, pready, pslverr, in_ready, irq;
  logic stb, rstart, rvalid, rerr;
  logic [7:0]  in_data = 8'h00, rbyte;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, ctrl = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_fa7b;
  logic [31:0] cfgs [5] = '{32'h0001, 32'h0003, 32'h0005, 32'h0007, 32'h007f};
  logic [16:0] sent [$];
  logic [16:0] e;
  int n_errors = 0, n_compared = 0, cyc = 0, idx = 0, plen = 188, rx_n = 0;
  tso_pkg::tso_pins_s pins;
  always #20 clk = ~clk;

  tso_top dut_u (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .power_on_reset_n_i(por_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .in_valid_i(in_valid),
    .in_data_i(in_data), .in_sop_i(in_sop), .in_err_i(in_err), .in_ready_o(in_ready),
    .output_byte_clock_o(pins.clk), .parallel_data_out_o(pins.pdata),
    .serial_data_out_o(pins.sdata), .packet_start_o(pins.sop),
    .packet_valid_strobe_o(pins.valid), .packet_error_flag_o(pins.err), .irq_o(irq));
  tso_sink sink_u (.core_clk_i(clk), .rst_i(rst), .pins_i(pins),
    .ctrl_i({ctrl[15:8], ctrl[6:0]}), .stb_o(stb), .byte_o(rbyte), .start_o(rstart),
    .valid_o(rvalid), .err_o(rerr));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic exp_valid(input logic [7:0] i, input logic red);
    return !red || i < 8'd188;
  endfunction : exp_valid
  task results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    {psel, pen} <= 2'b00;
  endtask : apb
  task run(input logic [31:0] c);
    chk_on = 0;
    apb(1, tso_pkg::OFF_CTRL, 32'h0000_0000);
    ctrl <= 32'h0000_0000;
    repeat (40) @(posedge clk);
    sent.delete();
    {idx, perr, rx_n, plen} = {32'd0, 1'b0, 32'd0, c[2] ? 32'd208 : 32'd188};
    {in_data, in_sop, in_err, in_valid} <= {seed[7:0], 3'b101};
    chk_on = 1;
    apb(1, tso_pkg::OFF_CTRL, c);
    ctrl <= c;
    while (rx_n < 2 * plen + 3) @(posedge clk);
    $display("done ctrl %h", c);
  endtask : run

  // source keeps valid high through each run so the output clock does not stall there; the underrun test drops it
  always @(posedge clk) if (in_valid && in_ready) begin
    sent.push_back({idx[7:0], perr, in_data});
    idx = (idx == plen - 1) ? 0 : idx + 1;
    seed = lfsr(seed);
    if (idx == 0) perr = ~perr; // every other packet errored
    {in_data, in_sop, in_err} <= {seed[7:0], idx == 0, perr};
  end
  // compare each received byte with the one the source handed over
  always @(posedge clk) if (stb && chk_on) begin
    rx_n++;
    if (sent.size() == 0) chk(1'b0, "byte out of nowhere");
    else begin
      e = sent.pop_front();
      chk(rbyte === e[7:0], "data");
      chk(rstart === (e[16:9] == 8'd0), "start");
      chk(rvalid === exp_valid(e[16:9], ctrl[2]), "valid");
      if (e[16:9] < 8'd188) chk(rerr === e[8], "error flag");
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    {rst, por_n} <= 2'b01;
    repeat (3) @(posedge clk);
    apb(0, tso_pkg::OFF_CTRL, 0);
    chk(rd === tso_pkg::CTRL_RST, "ctrl reset value");
    apb(0, tso_pkg::OFF_MASK, 0);
    chk(rd[3:0] === tso_pkg::MASK_RST, "mask reset value");
    apb(1, 12'h0010, 32'hffff_ffff);
    chk(slv === 1'b1, "unmapped write");
    apb(0, 12'h0010, 0);
    chk(rd === 32'h0000_0000 && slv === 1'b1, "unmapped read");
    foreach (cfgs[i]) run(cfgs[i]);
    chk_on = 0;
    apb(1, tso_pkg::OFF_CTRL, 0);
    apb(0, tso_pkg::OFF_STATUS, 0);
    chk(rd[1:0] === 2'b11, "status after packets");
    apb(1, tso_pkg::OFF_MASK, 32'h0000_0002);
    @(posedge clk);
    chk(irq === 1'b1, "irq raised");
    apb(1, tso_pkg::OFF_STATUS, 32'h0000_0003);
    @(posedge clk);
    chk(irq === 1'b0, "irq cleared");
    apb(0, tso_pkg::OFF_STATUS, 0);
    chk(rd[1:0] === 2'b00, "status cleared");
    apb(1, tso_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    in_valid <= 1'b0;
    repeat (40) @(posedge clk);
    apb(0, tso_pkg::OFF_STATUS, 0);
    chk(rd[2] === 1'b1, "underrun flagged");
    por_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pins === '0 && in_ready === 1'b0, "pins in power-on reset");
    por_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, tso_pkg::OFF_CTRL, 0);
    chk(rd === tso_pkg::CTRL_RST, "ctrl after power-on reset");
    results();
  end
endmodule : tb_top
